// ---- pin_edge_sync.sv ----
// Purpose: three-stage pin synchroniser with edge pulses
// Assumes: pin is asynchronous to sys_clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module pin_edge_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic rise;
        logic fall;
    } sync_t;

    sync_t state_reg;
    sync_t state_next;

    // stage one feeds stage two only; edges judged on two and three
    always_comb begin
        state_next = state_reg;
        state_next.s1 = pin_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        state_next.rise = 1'b0;
        state_next.fall = 1'b0;
        if (state_reg.s2 == state_reg.s3 && state_reg.s3 != state_reg.stable) begin
            state_next.stable = state_reg.s3;
            state_next.rise = state_reg.s3;
            state_next.fall = ~state_reg.s3;
        end
    end

    // pin idles high through its pull-up, so reset assumes high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, stable: 1'b1,
                           rise: 1'b0, fall: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level = state_reg.stable;
    assign rise = state_reg.rise;
    assign fall = state_reg.fall;
endmodule

// ---- pulse_source.sv ----
// Purpose: external pulse source driving the timer pin
// Assumes: pulse widths in sys_clk cycles, launched from bench edges
// Notes: pin rests at idle_level and goes to its inverse for a pulse;
// Notes: the 1 ns skew keeps pin changes off the sampling edge
`timescale 1ns/1ps
module pulse_source (
    input  wire logic        sys_clk,
    input  wire logic        fire,
    input  wire logic        idle_level,
    input  wire logic [15:0] width,
    output logic             pin,
    output logic             busy
);
    logic [15:0] left_reg = 16'h0000;

    // count down one pulse; a fire while busy is dropped
    always @(posedge sys_clk) begin
        if (fire && left_reg == 16'h0000) begin
            left_reg <= width;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end

    // driven pin: never floats, so no settling on a guessed level
    assign #1 pin = (left_reg != 16'h0000) ? ~idle_level : idle_level;
    assign busy = (left_reg != 16'h0000);
endmodule

// ---- pulse_width_capture_timer.sv ----
// Purpose: 8-bit timer, event counter and pulse width capture
// Assumes: single sys_clk domain, plain register port
// Notes: counter at ADDR_COUNT reads the count, writes the preload
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pulse_width_capture_timer (
    input  wire logic                           sys_clk,
    input  wire logic                           rst_n,
    input  wire logic [timer_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [7:0]                     reg_rdata,
    input  wire logic                           timer_input_pin,
    input  wire logic                           power_down,
    input  wire logic                           pull_high_en,
    output logic                                pin_pull_up,
    output logic                                timer_irq,
    output logic                                wake_up
);
    typedef struct packed {
        logic [7:0]                    ctrl;
        logic [7:0]                    count;
        logic [7:0]                    preload;
        logic                          irq_flag;
        logic                          irq_en;
        logic [timer_pkg::PSC_W-1:0]   psc;
        timer_pkg::cap_state_t         cap;
        logic                          pend_start;
        logic                          pend_stop;
        logic [7:0]                    rdata;
        logic                          wake;
        logic                          pull_up;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    logic                          pin_level;
    logic                          pin_rise;
    logic                          pin_fall;
    logic [1:0]                    mode;
    logic                          run;
    logic                          edge_sel;
    logic [2:0]                    psel;
    logic [timer_pkg::PSC_W-1:0]   psc_mask;
    logic                          tick;
    logic                          start_edge;
    logic                          stop_edge;
    logic                          event_edge;
    logic                          inhibit;
    logic                          cap_start_now;
    logic                          cap_stop_now;
    logic                          inc;
    logic                          ovf;

    // pin arrives asynchronously; edges come out as one-cycle pulses
    pin_edge_sync u_pin_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pin_in  (timer_input_pin),
        .level   (pin_level),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // control field decode
    assign mode = state_reg.ctrl[timer_pkg::MODE_HI:timer_pkg::MODE_LO];
    assign run = state_reg.ctrl[timer_pkg::RUN_BIT];
    assign edge_sel = state_reg.ctrl[timer_pkg::EDGE_BIT];
    assign psel = state_reg.ctrl[timer_pkg::PSC_HI:0];

    // prescaler tick: divide by two to the power of psel
    assign psc_mask = timer_pkg::PSC_W'((8'h01 << psel) - 8'h01);
    assign tick = ((state_reg.psc & psc_mask) == psc_mask);

    // only transitions matter, never the static level
    assign start_edge = edge_sel ? pin_rise : pin_fall;
    assign stop_edge = edge_sel ? pin_fall : pin_rise;
    assign event_edge = edge_sel ? pin_fall : pin_rise;

    // counter read or preload write steals the count that cycle
    assign inhibit = (reg_rd || reg_wr) && (reg_addr == timer_pkg::ADDR_COUNT);

    // capture start and stop edges are acted on at the next timer tick only
    assign cap_start_now = (state_reg.cap == timer_pkg::CAP_ARMED) && tick
                           && (state_reg.pend_start || start_edge);
    assign cap_stop_now = (state_reg.cap == timer_pkg::CAP_COUNT) && tick
                          && (state_reg.pend_stop || stop_edge);

    // increment source per mode
    always_comb begin
        inc = 1'b0;
        unique case (mode)
            timer_pkg::MODE_TIMER: inc = run && tick;
            timer_pkg::MODE_EVENT: inc = run && event_edge;
            timer_pkg::MODE_CAPT: begin
                inc = run && (state_reg.cap == timer_pkg::CAP_COUNT)
                      && tick && !cap_stop_now;
            end
            timer_pkg::MODE_NONE: inc = 1'b0;
        endcase
        if (inhibit) begin
            inc = 1'b0;
        end
    end

    assign ovf = inc && (state_reg.count == timer_pkg::COUNT_FULL);

    // next-state logic for the whole block
    always_comb begin
        state_next = state_reg;
        state_next.wake = 1'b0;
        state_next.psc = state_reg.psc + 7'h01;
        state_next.pull_up = pull_high_en;

        // capture sequencing
        if (mode != timer_pkg::MODE_CAPT || !run) begin
            state_next.cap = timer_pkg::CAP_IDLE;
            state_next.pend_start = 1'b0;
            state_next.pend_stop = 1'b0;
        end else begin
            unique case (state_reg.cap)
                timer_pkg::CAP_IDLE: begin
                    state_next.cap = timer_pkg::CAP_ARMED;
                end
                timer_pkg::CAP_ARMED: begin
                    if (cap_start_now) begin
                        state_next.cap = timer_pkg::CAP_COUNT;
                        state_next.pend_start = 1'b0;
                    end else if (start_edge) begin
                        state_next.pend_start = 1'b1;
                    end
                end
                timer_pkg::CAP_COUNT: begin
                    if (cap_stop_now) begin
                        // only capture may drop the run bit itself
                        state_next.cap = timer_pkg::CAP_IDLE;
                        state_next.pend_stop = 1'b0;
                        state_next.ctrl[timer_pkg::RUN_BIT] = 1'b0;
                    end else if (stop_edge) begin
                        state_next.pend_stop = 1'b1;
                    end
                end
                default: state_next.cap = timer_pkg::CAP_IDLE;
            endcase
        end

        // counting and overflow reload
        if (inc) begin
            if (ovf) begin
                state_next.count = state_reg.preload;
            end else begin
                state_next.count = state_reg.count + 8'h01;
            end
        end

        // flag set on every overflow; wake only if flag was clear
        if (ovf) begin
            state_next.irq_flag = 1'b1;
            state_next.wake = power_down && !state_reg.irq_flag;
        end

        // software writes; flag set beats a clear in the same cycle
        if (reg_wr) begin
            unique case (reg_addr)
                timer_pkg::ADDR_CTRL: begin
                    state_next.ctrl = reg_wdata & timer_pkg::CTRL_WMASK;
                end
                timer_pkg::ADDR_COUNT: begin
                    state_next.preload = reg_wdata;
                    if (!run) begin
                        state_next.count = reg_wdata;
                    end
                end
                timer_pkg::ADDR_STAT: begin
                    state_next.irq_en = reg_wdata[timer_pkg::IEN_BIT];
                    state_next.irq_flag = reg_wdata[timer_pkg::FLAG_BIT] || ovf;
                end
                default: state_next.ctrl = state_next.ctrl;
            endcase
        end

        // read data valid the cycle after the strobe only
        state_next.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                timer_pkg::ADDR_CTRL: state_next.rdata = state_reg.ctrl;
                timer_pkg::ADDR_COUNT: state_next.rdata = state_reg.count;
                timer_pkg::ADDR_STAT: begin
                    state_next.rdata = {6'h00, state_reg.irq_en, state_reg.irq_flag};
                end
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    // state register; counter reset value keeps power-on defined
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{ctrl: timer_pkg::CTRL_RESET,
                           count: timer_pkg::COUNT_RESET,
                           preload: timer_pkg::COUNT_RESET,
                           irq_flag: 1'b0,
                           irq_en: 1'b0,
                           psc: '0,
                           cap: timer_pkg::CAP_IDLE,
                           pend_start: 1'b0,
                           pend_stop: 1'b0,
                           rdata: 8'h00,
                           wake: 1'b0,
                           pull_up: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign reg_rdata = state_reg.rdata;
    assign timer_irq = state_reg.irq_flag && state_reg.irq_en;
    assign wake_up = state_reg.wake;
    assign pin_pull_up = state_reg.pull_up;

    // checks
    AST_CAP_ARM: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg.cap == timer_pkg::CAP_IDLE && mode == timer_pkg::MODE_CAPT
         && run && !reg_wr) |=> state_reg.cap == timer_pkg::CAP_ARMED)
        else $error("capture did not arm");

    AST_TIMER_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_TIMER && run && tick && !inhibit && !reg_wr
         && state_reg.count != timer_pkg::COUNT_FULL)
        |=> state_reg.count == $past(state_reg.count) + 8'h01)
        else $error("timer tick did not increment");

    AST_ARMED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_reg.cap == timer_pkg::CAP_ARMED && mode == timer_pkg::MODE_CAPT
         && !reg_wr) |=> $stable(state_reg.count))
        else $error("armed counter moved before start edge");

    AST_STOP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cap_stop_now && run && !reg_wr)
        |=> !run && state_reg.cap == timer_pkg::CAP_IDLE)
        else $error("stop edge did not clear run");

    AST_RUN_SW_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode != timer_pkg::MODE_CAPT && run && !reg_wr) |=> run)
        else $error("run bit dropped outside capture");

    AST_RESULT_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && !run && !reg_wr)
        |=> $stable(state_reg.count) && state_reg.cap == timer_pkg::CAP_IDLE)
        else $error("capture result changed after stop");

    AST_OVF_RELOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ovf && !reg_wr) |=> state_reg.count == $past(state_reg.preload)
        && state_reg.irq_flag)
        else $error("overflow did not reload and flag");

    AST_IRQ_GATED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ovf && !state_reg.irq_en && !reg_wr) |=> state_reg.irq_flag && !timer_irq)
        else $error("interrupt escaped its enable");

    AST_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ovf && power_down && !state_reg.irq_flag) |=> wake_up ##1 !wake_up)
        else $error("no wake pulse on powered-down overflow");

    AST_INHIBIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == timer_pkg::ADDR_COUNT) |=> $stable(state_reg.count))
        else $error("counter moved during read");

    AST_PRELOAD_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == timer_pkg::ADDR_COUNT && !run)
        |=> state_reg.count == $past(reg_wdata))
        else $error("preload write while off missed counter");

    AST_PULLUP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pull_high_en |=> pin_pull_up)
        else $error("pull-up dropped");

    // capture start: only the selected edge, acted on at a tick, may start it
    AST_START_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && run && cap_start_now && !reg_wr)
        |=> state_reg.cap == timer_pkg::CAP_COUNT)
        else $error("start tick did not begin counting");

    AST_NO_LEVEL_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && run && state_reg.cap == timer_pkg::CAP_ARMED
         && !state_reg.pend_start && !start_edge) |=> state_reg.cap != timer_pkg::CAP_COUNT)
        else $error("capture started without an edge");

    AST_FALL_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && run && !edge_sel && pin_rise
         && state_reg.cap == timer_pkg::CAP_ARMED && !state_reg.pend_start)
        |=> state_reg.cap == timer_pkg::CAP_ARMED && !state_reg.pend_start)
        else $error("rising edge started a falling-edge capture");

    AST_RISE_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && run && edge_sel && pin_fall
         && state_reg.cap == timer_pkg::CAP_ARMED && !state_reg.pend_start)
        |=> state_reg.cap == timer_pkg::CAP_ARMED && !state_reg.pend_start)
        else $error("falling edge started a rising-edge capture");

    AST_CAPT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && run && state_reg.cap == timer_pkg::CAP_COUNT && tick
         && !cap_stop_now && !inhibit && !reg_wr && state_reg.count != timer_pkg::COUNT_FULL)
        |=> state_reg.count == $past(state_reg.count) + 8'h01)
        else $error("capture tick did not increment");

    AST_TICK_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && !tick && !reg_wr) |=> $stable(state_reg.count))
        else $error("capture count moved between ticks");

    AST_STOP_FREEZE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_CAPT && cap_stop_now && !reg_wr)
        |=> $stable(state_reg.count))
        else $error("stop tick still counted");

    AST_EVENT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_EVENT && run && event_edge && !inhibit && !reg_wr
         && state_reg.count != timer_pkg::COUNT_FULL)
        |=> state_reg.count == $past(state_reg.count) + 8'h01)
        else $error("event edge not counted");

    AST_NONE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == timer_pkg::MODE_NONE && !reg_wr) |=> $stable(state_reg.count))
        else $error("counter moved with no mode");

    AST_PRELOAD_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == timer_pkg::ADDR_COUNT && run)
        |=> state_reg.preload == $past(reg_wdata) && $stable(state_reg.count))
        else $error("running preload write reached counter");

    // flag, prescaler and wake: overflow set must beat a software clear
    AST_FLAG_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == timer_pkg::ADDR_STAT)
        |=> state_reg.irq_flag == ($past(reg_wdata[timer_pkg::FLAG_BIT]) || $past(ovf)))
        else $error("flag write lost or beat an overflow");

    AST_PSC_PERIOD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && psel != 3'h0 && !reg_wr) |=> !tick)
        else $error("prescaler ticked twice in a row");

    AST_WAKE_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wake_up |-> $past(ovf) && $past(power_down))
        else $error("wake pulse without overflow");
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench for the pulse width capture timer
// Assumes: 250 MHz sys_clk, plain register port, fixed random seed
// Notes: pin sync latency makes measured widths loose by a few ticks
`timescale 1ns/1ps
module tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        power_down = 1'b0;
    logic        pull_high_en = 1'b0;
    logic        pin_pull_up;
    logic        timer_irq;
    logic        wake_up;
    logic        pin;
    logic        busy;
    logic        fire = 1'b0;
    logic        idle_level = 1'b1;
    logic [15:0] width = 16'h0000;
    logic [7:0]  d;
    logic [7:0]  cv;
    logic [7:0]  res;
    int          mismatches = 0;
    int          checks = 0;
    int          cycles = 0;
    int          wakes = 0;
    int          w;
    int          p;
    int          n;
    integer      seed = 32'h2ea3;

    always #2 sys_clk = ~sys_clk;

    pulse_width_capture_timer pulse_width_capture_timer_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_input_pin(pin), .power_down(power_down), .pull_high_en(pull_high_en),
        .pin_pull_up(pin_pull_up), .timer_irq(timer_irq), .wake_up(wake_up));

    pulse_source pulse_source_inst (
        .sys_clk(sys_clk), .fire(fire), .idle_level(idle_level), .width(width),
        .pin(pin), .busy(busy));

    // wake pulses and a cycle ceiling well above the planned run
    always @(posedge sys_clk) begin
        cycles++;
        if (wake_up === 1'b1) wakes++;
        if (cycles > 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // tolerance window folded to a one-bit verdict
    function automatic logic [7:0] fits(input logic [7:0] v, input int lo, input int hi);
        if ($isunknown(v)) return 8'h00;
        return {7'h00, (int'(v) >= lo && int'(v) <= hi)};
    endfunction

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic pulse(input int wd);
        @(posedge sys_clk);
        fire <= 1'b1;
        width <= wd[15:0];
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (wd + 10) @(posedge sys_clk);
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(2'h0, d); check("ctrl", d, 8'h08);
        rd(2'h3, d); check("unmapped", d, 8'h00);
        wr(2'h0, 8'hFF); rd(2'h0, d); check("ctrl", d, 8'hDF);
        wr(2'h0, 8'h08);
        @(posedge sys_clk) pull_high_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 check("pull", {7'h00, pin_pull_up}, 8'h01);
        // pin already at the start level: a static level must not start
        @(posedge sys_clk) idle_level <= 1'b0;
        repeat (10) @(posedge sys_clk);
        wr(2'h1, 8'h00); wr(2'h0, 8'hD0);
        repeat (20) @(posedge sys_clk);
        // the wrong edge must leave capture armed as well
        @(posedge sys_clk) idle_level <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rd(2'h1, d); check("count", d, 8'h00);
        rd(2'h0, d); check("ctrl", d, 8'hD0);
        wr(2'h0, 8'hD8);
        @(posedge sys_clk) idle_level <= 1'b0;
        repeat (20) @(posedge sys_clk);
        rd(2'h1, d); check("count", d, 8'h00);
        rd(2'h0, d); check("ctrl", d, 8'hD8);
        wr(2'h0, 8'hC0);
        // random captures, both edge polarities
        for (int k = 0; k < 6; k++) begin
            p = {$random(seed)} % 3;
            w = 8 + {$random(seed)} % 50;
            cv = 8'hC0 | (k[0] ? 8'h08 : 8'h00) | p[7:0];
            @(posedge sys_clk) idle_level <= ~k[0];
            repeat (8) @(posedge sys_clk);
            wr(2'h1, 8'h00); wr(2'h0, cv | 8'h10);
            repeat (5) @(posedge sys_clk);
            rd(2'h1, d); check("armed", d, 8'h00);
            pulse(w);
            rd(2'h0, d); check("ctrl", d, cv);
            rd(2'h1, d); check("width", fits(d, (w >> p) - 3, (w >> p) + 2), 8'h01);
            res = d;
            pulse(w + 3);
            rd(2'h1, d); check("held", d, res);
        end
        // overflow in capture while powered down
        @(posedge sys_clk) idle_level <= 1'b1;
        power_down <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wr(2'h1, 8'hF8); wr(2'h2, 8'h00);
        wakes = 0;
        wr(2'h0, 8'hD0);
        pulse(40);
        rd(2'h2, d); check("status", d, 8'h01);
        check("irq", {7'h00, timer_irq}, 8'h00);
        check("wakes", wakes[7:0], 8'h01);
        rd(2'h1, d); check("reload", fits(d, 248, 255), 8'h01);
        wr(2'h2, 8'h03); check("irq", {7'h00, timer_irq}, 8'h01);
        wr(2'h2, 8'h01); check("irq", {7'h00, timer_irq}, 8'h00);
        wr(2'h2, 8'h00); power_down <= 1'b0;
        // timer mode: preload waits, pin never clears run
        wr(2'h1, 8'h00); wr(2'h0, 8'h90); wr(2'h1, 8'hF0);
        rd(2'h1, d); check("preload", fits(d, 1, 15), 8'h01);
        pulse(10);
        rd(2'h0, d); check("ctrl", d, 8'h90);
        // mode none holds the count
        wr(2'h0, 8'h00); wr(2'h1, 8'h05); wr(2'h0, 8'h10);
        repeat (20) @(posedge sys_clk);
        rd(2'h1, d); check("count", d, 8'h05);
        // event mode, falling edges counted
        wr(2'h0, 8'h48); wr(2'h1, 8'h00); wr(2'h0, 8'h58);
        n = 3 + {$random(seed)} % 7;
        for (int i = 0; i < n; i++) pulse(3 + {$random(seed)} % 5);
        rd(2'h1, d); check("events", d, n[7:0]);
        rd(2'h0, d); check("ctrl", d, 8'h58);
        // every prescale ratio, sixteen ticks each
        for (int q = 0; q < 8; q++) begin
            wr(2'h0, 8'h80 | q[7:0]); wr(2'h1, 8'h00); wr(2'h0, 8'h90 | q[7:0]);
            repeat (16 << q) @(posedge sys_clk);
            rd(2'h1, d); check("prescale", fits(d, 14, 19), 8'h01);
        end
        wrap_up();
    end
endmodule

// ---- timer_pkg.sv ----
// Purpose: constants and types for the pulse width capture timer
// Assumes: 8-bit register port, 250 MHz sys_clk
// Notes: offsets are small indices on the plain register port
// Notes on behaviour
// - mode bits 7,6 both one select capture
// - capture counts prescaled system clock
// - run bit arms; counting waits for edge
// - edge bit zero: falling start, rising stop
// - edge bit one: rising start, falling stop
// - only capture clears run bit by hardware
// - counter holds final value after capture
// - later edges ignored until run set again
// - start and stop come from edges only
// - overflow flags, reloads preload, keeps counting
// - pin events taken at next timer tick; event mode counts its edges at once, without a tick
// - counter read or preload write inhibits count
// - overflow sets flag; irq needs enable
// - overflow while powered down, flag clear, gives wake-up
// - pull-high stays active in timer use
// - mode field: none, event, timer, capture
// - prescale divides by one up to 128
// - counter runs from preload up to FFH
// - preload write reaches counter only when off
package timer_pkg;
    localparam int          ADDR_W      = 2;
    localparam logic [1:0]  ADDR_CTRL   = 2'h0;
    localparam logic [1:0]  ADDR_COUNT  = 2'h1;
    localparam logic [1:0]  ADDR_STAT   = 2'h2;
    localparam logic [7:0]  CTRL_RESET  = 8'h08;
    localparam logic [7:0]  CTRL_WMASK  = 8'hDF;
    localparam int          MODE_HI     = 7;
    localparam int          MODE_LO     = 6;
    localparam int          RUN_BIT     = 4;
    localparam int          EDGE_BIT    = 3;
    localparam int          PSC_HI      = 2;
    localparam int          FLAG_BIT    = 0;
    localparam int          IEN_BIT     = 1;
    localparam logic [1:0]  MODE_NONE   = 2'h0;
    localparam logic [1:0]  MODE_EVENT  = 2'h1;
    localparam logic [1:0]  MODE_TIMER  = 2'h2;
    localparam logic [1:0]  MODE_CAPT   = 2'h3;
    localparam logic [7:0]  COUNT_FULL  = 8'hFF;
    localparam logic [7:0]  COUNT_RESET = 8'h00;
    localparam int          PSC_W       = 7;
    typedef enum logic [1:0] {CAP_IDLE, CAP_ARMED, CAP_COUNT} cap_state_t;
endpackage
